// ===== hdl/scac_pkg.sv
package scac_pkg;
  // Register indices on the register port
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_EVENT = 4'h2;
  localparam logic [3:0] ADDR_DIV = 4'h3;
  localparam logic [3:0] ADDR_BRK = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h5;
  localparam logic [3:0] ADDR_HOLD = 4'h6;
  localparam logic [3:0] ADDR_STAT = 4'h7;
  localparam logic [3:0] ADDR_RXLEN = 4'h8;
  // Reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] RXLEN_RST = 16'h0001;
  // Mode register fields
  localparam int MODE_PROTO_LSB = 0;
  localparam int MODE_TX_ON = 2;
  localparam int MODE_RX_ON = 3;
  localparam int MODE_DIAG_LSB = 4;
  localparam int MODE_MULTIDROP = 6;
  localparam int MODE_TIMER_SRC = 7;
  localparam int MODE_PRESCALE_BY_FOUR = 8;
  localparam logic [1:0] PROTO_ASYNC = 2'h1;
  localparam logic [1:0] DIAG_NORMAL = 2'h0;
  // Control character register: reject flag above the character
  localparam int CTRL_REJECT = 8;
  // Event bits, shared by the event and mask registers
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_BUSY = 2;
  localparam int EV_CCR = 3;
  localparam int EV_BRK = 4;
  // Commands
  localparam logic [1:0] CMD_HALT_TX = 2'h0;
  localparam logic [1:0] CMD_RESUME_TX = 2'h1;
  localparam logic [1:0] CMD_HUNT = 2'h2;
  // Bit timing counts
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [3:0] LAST_DATA_IDX = 4'h8;
  localparam logic [3:0] IDLE_BITS = 4'ha;
  localparam logic [2:0] POLL_LAST = 3'h7;
  localparam logic [1:0] PRE4_LAST = 2'h3;
  // Transmit FIFO shape: {clear_to_send_report, last, data}
  localparam int TXF_WIDTH = 10;
  localparam int TXF_DEPTH = 32;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_BREAK = 2'b10
  } scac_tx_state_t;
endpackage

// ===== hdl/scac_top.sv
`timescale 1ns/1ps
// Function
// - Rate clock is source clock over divider plus one, then over one or four.
// - Synchronous protocols use the rate clock as bit clock, no oversampling.
// - Sixteen-bit read-write serial_mode_reg, zero after reset.
// - Mode bits 5..0: protocol, transmitter_on, receiver_on, diagnostic_select.
// - Normal diagnostic mode gates transmit by CTS and receive by CD.
// - Enabled transmitter polls for data about every eight transmit clocks.
// - Halt aborts message, finishes queued character, keeps tx_descriptor_index.
// - After halt send break_count_reg breaks, then idle.
// - Resume continues from current tx_descriptor_index, also after lost CTS.
// - Enabled receiver starts storing into its first buffer.
// - Hunt command closes current buffer with receive event if it holds characters, enters hunt.
// - Hunt ends on address character in multidrop, else one idle character.
// - Hunt command discards a character whose stop bit is sampled in the same cycle.
// - Flag break_seen on break, control_char_seen on rejected control character.
// - Character with no free buffer is dropped, flags no_buffer_drop, multidrop hunts.
// - Buffer availability is sampled at the middle of the stop bit.
// - Transmit done at last data bit start, or on FIFO entry if unreported.
// - Receive done no earlier than middle of the closing character's stop bit.
// - Eight-bit event_mask_reg, one enables that event, zero after reset.
// - command_pending clears once the command has executed.
module scac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  // Storage has no reset; only pointers carry meaning
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Full and empty come from flops so both readies are glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
        in_ready <= (count_reg != (AW + 1)'(DEPTH - 1));
        out_valid <= 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
        in_ready <= 1'b1;
        out_valid <= (count_reg != (AW + 1)'(1));
      end
    end
  end
endmodule

module scac_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  output logic command_pending,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_report,
  output logic [15:0] tx_descriptor_index,
  input wire logic rx_buf_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_close,
  output logic irq,
  input wire logic timer_input_clock,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic cd_n,
  output logic txd
);
  logic [15:0] serial_mode_reg;
  logic [7:0] event_mask_reg;
  logic [7:0] event_reg;
  logic [15:0] div_reg;
  logic [15:0] break_count_reg;
  logic [8:0] ctrl_char_reg;
  logic [7:0] control_char_holding;
  logic [15:0] rx_len_reg;
  logic [2:0] tim_sync;
  logic [1:0] rxd_sync;
  logic [1:0] cts_sync;
  logic [1:0] cd_sync;
  logic [15:0] div_cnt_reg;
  logic [1:0] pre_cnt_reg;
  logic rate_tick;
  logic src_tick;
  logic sync_proto;
  logic tx_allow;
  logic rx_allow;
  logic multidrop;
  logic [3:0] tx_os_reg;
  logic tx_bit_tick;
  scac_pkg::scac_tx_state_t tx_state_reg;
  logic [9:0] tx_shift_reg;
  logic [3:0] tx_idx_reg;
  logic tx_cur_last_reg;
  logic tx_cur_rep_reg;
  logic [2:0] poll_cnt_reg;
  logic tx_halted_reg;
  logic [15:0] brk_left_reg;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [9:0] fifo_out_data;
  logic tx_push;
  logic tx_done_ev;
  logic cts_lost;
  logic [3:0] rx_os_reg;
  logic [3:0] rx_idx_reg;
  logic rx_busy_reg;
  logic [8:0] rx_shift_reg;
  logic rx_sample;
  logic rx_stop;
  logic hunting_reg;
  logic [3:0] idle_cnt_reg;
  logic [15:0] rx_cnt_reg;
  logic cmd_take;
  logic [7:0] ev_set;
  logic ev_rx;
  logic ev_busy;
  logic ev_ccr;
  logic ev_brk;

  // Last oversample slot of a bit; every rate tick in synchronous modes
  function automatic logic [3:0] os_end(input logic sync);
    os_end = sync ? 4'h0 : scac_pkg::OS_LAST;
  endfunction

  // Pins from the line and the timer clock are foreign, two flops each for the line, three for the timer clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tim_sync <= 3'h0;
      rxd_sync <= 2'h3;
      cts_sync <= 2'h3;
      cd_sync <= 2'h3;
    end else if (ce) begin
      tim_sync <= {tim_sync[1:0], timer_input_clock};
      rxd_sync <= {rxd_sync[0], rxd};
      cts_sync <= {cts_sync[0], cts_n};
      cd_sync <= {cd_sync[0], cd_n};
    end
  end

  assign sync_proto = serial_mode_reg[1:0] != scac_pkg::PROTO_ASYNC;
  assign multidrop = serial_mode_reg[scac_pkg::MODE_MULTIDROP];
  // Edge of the timer clock is taken from the second and third flops only
  assign src_tick = serial_mode_reg[scac_pkg::MODE_TIMER_SRC] ? (tim_sync[1] && !tim_sync[2]) : 1'b1;
  // Modem lines only gate the channel in normal diagnostic mode
  assign tx_allow = serial_mode_reg[scac_pkg::MODE_TX_ON] &&
                    (serial_mode_reg[5:4] != scac_pkg::DIAG_NORMAL || !cts_sync[1]);
  assign rx_allow = serial_mode_reg[scac_pkg::MODE_RX_ON] &&
                    (serial_mode_reg[5:4] != scac_pkg::DIAG_NORMAL || !cd_sync[1]);

  // Rate generator: divider first, then the optional divide by four
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt_reg <= 16'h0000;
      pre_cnt_reg <= 2'h0;
      rate_tick <= 1'b0;
    end else if (ce) begin
      rate_tick <= 1'b0;
      if (src_tick) begin
        if (div_cnt_reg >= div_reg) begin
          div_cnt_reg <= 16'h0000;
          if (!serial_mode_reg[scac_pkg::MODE_PRESCALE_BY_FOUR] || pre_cnt_reg == scac_pkg::PRE4_LAST) begin
            pre_cnt_reg <= 2'h0;
            rate_tick <= 1'b1;
          end else begin
            pre_cnt_reg <= pre_cnt_reg + 2'h1;
          end
        end else begin
          div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Transmit bit clock: rate over sixteen async, rate itself when synchronous
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_os_reg <= 4'h0;
    end else if (ce && rate_tick) begin
      tx_os_reg <= (tx_os_reg >= os_end(sync_proto)) ? 4'h0 : tx_os_reg + 4'h1;
    end
  end
  assign tx_bit_tick = rate_tick && (tx_os_reg >= os_end(sync_proto));

  // Register writes; the mode word is fully read-write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_mode_reg <= scac_pkg::MODE_RST;
      event_mask_reg <= scac_pkg::MASK_RST;
      div_reg <= scac_pkg::DIV_RST;
      break_count_reg <= 16'h0000;
      ctrl_char_reg <= 9'h000;
      rx_len_reg <= scac_pkg::RXLEN_RST;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        scac_pkg::ADDR_MODE: serial_mode_reg <= reg_wdata;
        scac_pkg::ADDR_MASK: event_mask_reg <= reg_wdata[7:0];
        scac_pkg::ADDR_DIV: div_reg <= reg_wdata;
        scac_pkg::ADDR_BRK: break_count_reg <= reg_wdata;
        scac_pkg::ADDR_CTRL: ctrl_char_reg <= reg_wdata[8:0];
        scac_pkg::ADDR_RXLEN: rx_len_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped indices read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce && reg_rd) begin
      unique case (reg_addr)
        scac_pkg::ADDR_MODE: reg_rdata <= serial_mode_reg;
        scac_pkg::ADDR_MASK: reg_rdata <= {8'h00, event_mask_reg};
        scac_pkg::ADDR_EVENT: reg_rdata <= {8'h00, event_reg};
        scac_pkg::ADDR_DIV: reg_rdata <= div_reg;
        scac_pkg::ADDR_BRK: reg_rdata <= break_count_reg;
        scac_pkg::ADDR_CTRL: reg_rdata <= {7'h00, ctrl_char_reg};
        scac_pkg::ADDR_HOLD: reg_rdata <= {8'h00, control_char_holding};
        scac_pkg::ADDR_STAT: reg_rdata <= {12'h000, tx_state_reg == scac_pkg::TX_BREAK,
                                           hunting_reg, rx_busy_reg, tx_halted_reg};
        scac_pkg::ADDR_RXLEN: reg_rdata <= rx_len_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // One command at a time; it executes in the same cycle it is taken
  assign cmd_take = cmd_valid && !command_pending;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      command_pending <= 1'b0;
    end else if (ce) begin
      command_pending <= cmd_take;
    end
  end

  // Transmit queue; its ready is the writer's back-pressure
  scac_fifo #(
    .WIDTH(scac_pkg::TXF_WIDTH),
    .DEPTH(scac_pkg::TXF_DEPTH)
  ) u_tx_fifo (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data({tx_report, tx_last, tx_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  assign tx_push = tx_valid && tx_ready;

  // A character is fetched only on a poll slot, so a late write waits a poll
  assign fifo_out_ready = tx_state_reg == scac_pkg::TX_IDLE && tx_bit_tick && tx_allow &&
                          !tx_halted_reg && poll_cnt_reg == scac_pkg::POLL_LAST;
  // Losing CTS mid-character is an error that needs a resume
  assign cts_lost = tx_state_reg == scac_pkg::TX_SHIFT && serial_mode_reg[5:4] == scac_pkg::DIAG_NORMAL &&
                    cts_sync[1];
  assign tx_done_ev = (tx_push && tx_last && !tx_report) ||
                      (tx_bit_tick && tx_state_reg == scac_pkg::TX_SHIFT && tx_idx_reg == scac_pkg::LAST_DATA_IDX &&
                       tx_cur_last_reg && tx_cur_rep_reg);

  // Transmitter: shifts start, eight data, stop; breaks are a frame of zeros
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state_reg <= scac_pkg::TX_IDLE;
      tx_shift_reg <= 10'h3ff;
      tx_idx_reg <= 4'h0;
      tx_cur_last_reg <= 1'b0;
      tx_cur_rep_reg <= 1'b0;
      poll_cnt_reg <= 3'h0;
      tx_halted_reg <= 1'b0;
      brk_left_reg <= 16'h0000;
      txd <= 1'b1;
    end else if (ce) begin
      if (cmd_take && cmd_code == scac_pkg::CMD_HALT_TX) begin
        tx_halted_reg <= 1'b1;
        brk_left_reg <= break_count_reg;
      end else if (cmd_take && cmd_code == scac_pkg::CMD_RESUME_TX) begin
        tx_halted_reg <= 1'b0;
      end else if (cts_lost) begin
        tx_halted_reg <= 1'b1;
      end
      if (cts_lost) begin
        tx_state_reg <= scac_pkg::TX_IDLE;
        txd <= 1'b1;
      end else if (tx_bit_tick) begin
        unique case (tx_state_reg)
          scac_pkg::TX_IDLE: begin
            txd <= 1'b1;
            poll_cnt_reg <= poll_cnt_reg + 3'h1;
            if (fifo_out_ready && fifo_out_valid) begin
              tx_shift_reg <= {1'b1, fifo_out_data[7:0], 1'b0};
              tx_cur_last_reg <= fifo_out_data[8];
              tx_cur_rep_reg <= fifo_out_data[9];
              tx_idx_reg <= 4'h0;
              tx_state_reg <= scac_pkg::TX_SHIFT;
            end else if (tx_halted_reg && brk_left_reg != 16'h0000) begin
              brk_left_reg <= brk_left_reg - 16'h0001;
              tx_idx_reg <= 4'h0;
              tx_state_reg <= scac_pkg::TX_BREAK;
            end
          end
          scac_pkg::TX_SHIFT: begin
            txd <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_idx_reg <= tx_idx_reg + 4'h1;
            // Halt only lets the character already in the shifter finish
            if (tx_idx_reg == scac_pkg::STOP_IDX) begin
              tx_state_reg <= scac_pkg::TX_IDLE;
            end
          end
          scac_pkg::TX_BREAK: begin
            txd <= 1'b0;
            tx_idx_reg <= tx_idx_reg + 4'h1;
            if (tx_idx_reg == scac_pkg::STOP_IDX) begin
              tx_state_reg <= scac_pkg::TX_IDLE;
            end
          end
          default: tx_state_reg <= scac_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // Index moves only on a finished buffer, never on halt
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_descriptor_index <= 16'h0000;
    end else if (ce && tx_done_ev) begin
      tx_descriptor_index <= tx_descriptor_index + 16'h0001;
    end
  end

  // Receive sampling: find start edge, confirm mid start, then every bit
  assign rx_sample = rate_tick && rx_busy_reg && rx_os_reg == (sync_proto ? 4'h0 : scac_pkg::OS_MID);
  assign rx_stop = rx_sample && rx_idx_reg == scac_pkg::STOP_IDX;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_busy_reg <= 1'b0;
      rx_os_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else if (ce && rate_tick) begin
      if (!rx_busy_reg) begin
        if (rxd_sync[1]) begin
          rx_idx_reg <= 4'h0; // A break must end before a new start
        end else if (rx_allow && rx_idx_reg == 4'h0) begin
          rx_busy_reg <= 1'b1;
          rx_os_reg <= 4'h1;
        end
      end else begin
        rx_os_reg <= (rx_os_reg >= os_end(sync_proto)) ? 4'h0 : rx_os_reg + 4'h1;
        if (rx_sample) begin
          rx_shift_reg <= {rxd_sync[1], rx_shift_reg[8:1]};
          rx_idx_reg <= rx_idx_reg + 4'h1;
          // A false start (line high at mid start) is dropped
          if ((rx_idx_reg == 4'h0 && rxd_sync[1]) || rx_idx_reg == scac_pkg::STOP_IDX) begin
            rx_busy_reg <= 1'b0;
          end
        end
      end
    end
  end

  // Idle character: a full frame time of marking line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      idle_cnt_reg <= 4'h0;
    end else if (ce && rate_tick && tx_os_reg >= os_end(sync_proto)) begin
      if (!rxd_sync[1] || rx_busy_reg) begin
        idle_cnt_reg <= 4'h0;
      end else if (idle_cnt_reg != scac_pkg::IDLE_BITS) begin
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
      end
    end
  end

  // Character handling at mid stop bit; buffer readiness sampled there too
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hunting_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_valid <= 1'b0;
      rx_close <= 1'b0;
      rx_data <= 8'h00;
      control_char_holding <= 8'h00;
      ev_rx <= 1'b0;
      ev_busy <= 1'b0;
      ev_ccr <= 1'b0;
      ev_brk <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      rx_close <= 1'b0;
      ev_rx <= 1'b0;
      ev_busy <= 1'b0;
      ev_ccr <= 1'b0;
      ev_brk <= 1'b0;
      if (cmd_take && cmd_code == scac_pkg::CMD_HUNT) begin
        // Closes the open buffer; characters already handed out stay delivered
        hunting_reg <= 1'b1;
        rx_cnt_reg <= 16'h0000;
        rx_close <= rx_cnt_reg != 16'h0000;
        ev_rx <= rx_cnt_reg != 16'h0000;
      end else if (hunting_reg && !multidrop && idle_cnt_reg == scac_pkg::IDLE_BITS) begin
        hunting_reg <= 1'b0;
      end else if (rx_stop) begin
        if (rx_shift_reg == 9'h000 && !rxd_sync[1]) begin
          ev_brk <= 1'b1;
        end else if (hunting_reg && !(multidrop && rx_shift_reg[8])) begin
          hunting_reg <= 1'b1;
        end else if (ctrl_char_reg[scac_pkg::CTRL_REJECT] && rx_shift_reg[8:1] == ctrl_char_reg[7:0]) begin
          control_char_holding <= rx_shift_reg[8:1];
          ev_ccr <= 1'b1;
        end else if (!rx_buf_ready) begin
          ev_busy <= 1'b1;
          hunting_reg <= multidrop;
        end else begin
          hunting_reg <= 1'b0;
          rx_valid <= 1'b1;
          rx_data <= rx_shift_reg[8:1];
          if (rx_cnt_reg + 16'h0001 >= rx_len_reg) begin
            rx_cnt_reg <= 16'h0000;
            rx_close <= 1'b1;
            ev_rx <= 1'b1;
          end else begin
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
          end
        end
      end
    end
  end

  // Event flags: write one to clear, a new event in the same cycle wins
  always_comb begin
    ev_set = 8'h00;
    ev_set[scac_pkg::EV_RX] = ev_rx;
    ev_set[scac_pkg::EV_TX] = tx_done_ev;
    ev_set[scac_pkg::EV_BUSY] = ev_busy;
    ev_set[scac_pkg::EV_CCR] = ev_ccr;
    ev_set[scac_pkg::EV_BRK] = ev_brk;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_reg <= 8'h00;
    end else if (ce) begin
      if (reg_wr && reg_addr == scac_pkg::ADDR_EVENT) begin
        event_reg <= (event_reg & ~reg_wdata[7:0]) | ev_set;
      end else begin
        event_reg <= event_reg | ev_set;
      end
    end
  end

  // Request follows the flags one cycle later, straight from a flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(event_reg & event_mask_reg);
    end
  end
endmodule

// ===== tb/scac_monitor.sv
`timescale 1ns/1ps
module scac_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic command_pending,
  input wire logic rx_buf_ready,
  input wire logic rx_valid,
  input wire logic rx_close,
  input wire logic irq,
  input wire logic cts_n,
  input wire logic txd
);
  logic [15:0] mode_q;
  logic [7:0] mask_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow copies let read-back and masking be predicted without the design
  always_ff @(posedge core_clk) begin
    if (rst) mode_q <= 16'h0000;
    else if (ce && reg_wr && reg_addr == scac_pkg::ADDR_MODE) mode_q <= reg_wdata;
  end
  always_ff @(posedge core_clk) begin
    if (rst) mask_q <= 8'h00;
    else if (ce && reg_wr && reg_addr == scac_pkg::ADDR_MASK) mask_q <= reg_wdata[7:0];
  end
  property p_rst; $past(rst) |-> reg_rdata == 16'h0000 && !irq && txd && !command_pending; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_mode; ce && reg_rd && reg_addr == scac_pkg::ADDR_MODE |=> reg_rdata == $past(mode_q); endproperty
  a_mode: assert property (p_mode) else $error("mode read-back wrong");
  property p_mask; ce && reg_rd && reg_addr == scac_pkg::ADDR_MASK |=> reg_rdata == {8'h00, $past(mask_q)}; endproperty
  a_mask: assert property (p_mask) else $error("mask read-back wrong");
  property p_irq; $past(mask_q) == 8'h00 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq with all events masked");
  property p_cmd; ce && cmd_valid && !command_pending |=> command_pending ##1 !command_pending; endproperty
  a_cmd: assert property (p_cmd) else $error("command pending flag wrong");
  property p_rx; rx_valid |-> $past(rx_buf_ready) && $past(rx_buf_ready, 2); endproperty
  a_rx: assert property (p_rx) else $error("char stored without free buffer");
  property p_start; $fell(txd) |-> (!txd) [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_cts; mode_q[5:4] == 2'h0 && cts_n && $past(cts_n) && $past(cts_n, 2) && txd |=> txd; endproperty
  a_cts: assert property (p_cts) else $error("sent while clear to send lost");
  c_cmd: cover property (ce && cmd_valid && !command_pending);
  c_rx: cover property (rx_valid);
  c_close: cover property (rx_close);
endmodule
bind scac_top scac_monitor u_mon (.*);

// ===== tb/scac_remote.sv
`timescale 1ns/1ps
module scac_remote (
  input wire logic core_clk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n,
  output logic cd_n
);
  localparam int BT = 16;
  logic [7:0] got;
  logic [7:0] last_byte;
  int n_rx;
  initial begin
    {rxd, cts_n, cd_n} = 3'b100;
    n_rx = 0;
  end
  // One frame, LSB first; data 0 with stop 0 makes a break
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      #1 rxd = (i < 10) ? f[i] : 1'b1;
      repeat (BT - 1) @(posedge core_clk);
    end
  endtask
  // Sample on the falling clock edge so no race with the line's update
  initial forever begin
    @(negedge txd);
    repeat (BT / 2) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(negedge core_clk);
      got[i] = txd;
    end
    repeat (BT) @(negedge core_clk);
    if (txd) begin
      last_byte = got;
      n_rx++;
    end
  end
endmodule

// ===== tb/scac_tb_top.sv
`timescale 1ns/1ps
module scac_tb_top;
  logic core_clk, rst, ce, reg_wr, reg_rd, cmd_valid, command_pending, tx_valid, tx_ready, tx_last, tx_report;
  logic rx_buf_ready, rx_valid, rx_close, irq, timer_input_clock, rxd, cts_n, cd_n, txd, v, cl;
  logic [3:0] reg_addr;
  logic [1:0] cmd_code;
  logic [7:0] tx_data, rx_data, rxb;
  logic [15:0] reg_wdata, reg_rdata, tx_descriptor_index, d;
  int bad_count = 0;
  int n_compared = 0;
  int k;
  scac_top dut (.*);
  scac_remote remote (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Latch receive pulses so a scenario can judge them after the frame
  always @(posedge core_clk) begin
    if (rx_valid) v <= 1'b1;
    if (rx_valid) rxb <= rx_data;
    if (rx_close) cl <= 1'b1;
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge core_clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, w};
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge core_clk);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    chk($sformatf("reg %h", a), e, reg_rdata & m);
  endtask
  task automatic cmd(input logic [1:0] c);
    @(posedge core_clk);
    #1 {cmd_valid, cmd_code} = {1'b1, c};
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    chk("pending", 16'h0001, {15'h0, command_pending});
    @(posedge core_clk);
    #1 chk("pending", 16'h0000, {15'h0, command_pending});
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge core_clk);
    #1 {tx_valid, tx_data} = {1'b1, b};
  endtask
  // A wait that runs out ends the run at once
  task automatic wait_frames(input int n);
    for (k = 0; k < 20000 && remote.n_rx < n; k++) @(posedge core_clk);
    #1 chk("frames", 16'(n), 16'(remote.n_rx));
    if (remote.n_rx < n) print_verdict();
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000 bad_count++;
    print_verdict();
  end
  initial begin
    {rst, ce, reg_wr, reg_rd, cmd_valid, tx_valid, tx_last, tx_report} = 8'b11000011;
    {reg_addr, reg_wdata, cmd_code, tx_data, rx_buf_ready, timer_input_clock, v, cl} = 34'h8;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    rc(scac_pkg::ADDR_MODE, 16'h0000, 16'hffff);
    rc(scac_pkg::ADDR_MASK, 16'h0000, 16'hffff);
    rc(4'hf, 16'h0000, 16'hffff);
    wr(scac_pkg::ADDR_MASK, 16'hffff);
    rc(scac_pkg::ADDR_MASK, 16'h00ff, 16'hffff);
    wr(scac_pkg::ADDR_MASK, 16'h0002);
    for (int i = 0; i < 32; i++) begin
      push(8'(i));
      chk("tx_ready", 16'h0001, {15'h0, tx_ready});
    end
    @(posedge core_clk);
    #1 tx_valid = 1'b0;
    chk("tx_ready", 16'h0000, {15'h0, tx_ready});
    chk("index", 16'h0000, tx_descriptor_index);
    remote.cts_n = 1'b1;
    wr(scac_pkg::ADDR_MODE, 16'h000d);
    rc(scac_pkg::ADDR_MODE, 16'h000d, 16'hffff);
    repeat (300) @(posedge core_clk);
    #1 remote.cts_n = 1'b0;
    wait_frames(32);
    chk("last", 16'h001f, {8'h00, remote.last_byte});
    chk("index", 16'h0020, tx_descriptor_index);
    chk("irq", 16'h0001, {15'h0, irq});
    rc(scac_pkg::ADDR_EVENT, 16'h0002, 16'hffff);
    wr(scac_pkg::ADDR_EVENT, 16'h0002);
    rc(scac_pkg::ADDR_EVENT, 16'h0000, 16'hffff);
    chk("irq", 16'h0000, {15'h0, irq});
    wr(scac_pkg::ADDR_RXLEN, 16'h0002);
    remote.send(8'h3c, 1'b1);
    chk("rx", 16'h013c, {7'h0, v, rxb});
    {v, cl} = 2'b00;
    remote.send(8'ha5, 1'b1);
    chk("rx", 16'h03a5, {6'h0, cl, v, rxb});
    {v, rx_buf_ready} = 2'b00;
    remote.send(8'h11, 1'b1);
    chk("dropped", 16'h0000, {15'h0, v});
    rc(scac_pkg::ADDR_EVENT, 16'h0005, 16'hffff);
    wr(scac_pkg::ADDR_EVENT, 16'h00ff);
    rx_buf_ready = 1'b1;
    wr(scac_pkg::ADDR_CTRL, 16'h017e);
    remote.send(8'h7e, 1'b1);
    chk("ctrl kept out", 16'h0000, {15'h0, v});
    remote.send(8'h00, 1'b0);
    rc(scac_pkg::ADDR_HOLD, 16'h007e, 16'hffff);
    rc(scac_pkg::ADDR_EVENT, 16'h0018, 16'h0018);
    remote.send(8'h42, 1'b1);
    cmd(scac_pkg::CMD_HUNT);
    rc(scac_pkg::ADDR_STAT, 16'h0004, 16'h0004);
    rc(scac_pkg::ADDR_EVENT, 16'h0001, 16'h0001);
    repeat (400) @(posedge core_clk);
    rc(scac_pkg::ADDR_STAT, 16'h0000, 16'h0004);
    wr(scac_pkg::ADDR_BRK, 16'h0001);
    cmd(scac_pkg::CMD_HALT_TX);
    for (k = 0; k < 400 && txd; k++) @(posedge core_clk);
    for (k = 0; k < 400 && !txd; k++) @(posedge core_clk);
    chk("break", 16'h0001, {15'h0, k >= 159 && k <= 161});
    rc(scac_pkg::ADDR_STAT, 16'h0001, 16'h0001);
    wr(scac_pkg::ADDR_MODE, 16'h0009);
    cmd(scac_pkg::CMD_RESUME_TX);
    wr(scac_pkg::ADDR_MODE, 16'h000d);
    push(8'h77);
    @(posedge core_clk);
    #1 tx_valid = 1'b0;
    wait_frames(33);
    chk("last", 16'h0077, {8'h00, remote.last_byte});
    chk("index", 16'h0021, tx_descriptor_index);
    cmd(2'h3);
    print_verdict();
  end
endmodule
